/* File: verif/irq_host_model.sv */
// host model: resolves the interrupt wire and reports whether it is asserted
`timescale 1ns/1ps
`default_nettype none
module irq_host_model (
  // interrupt pin as driven by the device
  input  wire logic irq_pin_out,
  input  wire logic irq_pin_oe,
  // host view of the line
  input  wire logic active_low,
  output logic      irq_seen
);
  // board pull-up holds the line high whenever the pin is released
  wire logic line_level;
  assign line_level = irq_pin_oe ? irq_pin_out : 1'b1;
  assign irq_seen   = line_level ^ active_low;
endmodule // irq_host_model
`default_nettype wire

/* File: verif/testbench.sv */
// self-checking bench for the motion interrupt controller
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic                          core_clk = 1'b0;
  logic                          reset_n = 1'b0;
  logic [5:0]                    evt = '0;
  motion_irq_pkg::accel_sample_t accel_in = '0;
  logic [6:0]                    irq_enable = '0;
  motion_irq_pkg::pin_config_t   pin_cfg = '0;
  logic [7:0]                    cnt_thr = 8'h00;
  logic [1:0]                    dec_ctl = 2'h0;
  logic [3:0]                    hpf_shift = 4'h0;
  logic                          status_read = 1'b0;
  logic                          status_clear = 1'b0;
  logic [6:0]                    irq_status;
  motion_irq_pkg::axis_status_t  axis;
  logic [7:0]                    count;
  logic                          pin_out;
  logic                          pin_oe;
  logic                          irq_seen;
  logic signed [15:0]            x_last = '0;
  int                            n_errors = 0;
  int                            n_compared = 0;
  int                            cycles = 0;

  motion_interrupt_controller dut (.core_clk(core_clk), .reset_n(reset_n),
    .clk_lock_evt(evt[0]), .data_ready_evt(evt[1]), .fifo_overflow_evt(evt[2]),
    .aux_nack_evt(evt[3]), .aux_arb_lost_evt(evt[4]), .slv4_done_evt(evt[5]),
    .accel_in(accel_in), .irq_enable(irq_enable), .pin_cfg(pin_cfg),
    .accel_highpass_filter(hpf_shift), .motion_accel_threshold(8'h64),
    .motion_count_threshold(cnt_thr), .motion_decrement_control(dec_ctl),
    .status_read(status_read), .status_clear(status_clear), .irq_status(irq_status),
    .motion_axis_status(axis), .motion_count(count), .irq_pin_out(pin_out),
    .irq_pin_oe(pin_oe));
  irq_host_model host (.irq_pin_out(pin_out), .irq_pin_oe(pin_oe),
    .active_low(pin_cfg.active_low), .irq_seen(irq_seen));

  always #5 core_clk = ~core_clk;

  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // a hang counts as a mismatch and still reaches the report
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      $display("ERROR timeout expected 5000 seen %0d", cycles);
      complete_run();
    end
  end

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic pulse_evt(input int i);
    @(negedge core_clk);
    evt[i] = 1'b1;
    @(negedge core_clk);
    evt = '0;
  endtask

  // filter shift 0 makes the filtered value x minus previous x
  task automatic sample(input logic signed [15:0] x);
    @(negedge core_clk);
    accel_in.valid = 1'b1;
    accel_in.x = x;
    @(negedge core_clk);
    accel_in.valid = 1'b0;
    x_last = x;
  endtask

  task automatic build(input int n);
    repeat (n) sample(x_last > 0 ? -16'sd200 : 16'sd200);
  endtask

  task automatic dec_case(input int start, input logic [1:0] mode, input logic [7:0] exp);
    dec_ctl = 2'h0;
    sample(x_last);
    build(start);
    chk("count_built", 16'(start), {8'h00, count});
    dec_ctl = mode;
    sample(x_last);
    chk("count_drop", {8'h00, exp}, {8'h00, count});
  endtask

  initial begin
    repeat (20) @(negedge core_clk);
    reset_n = 1'b1;
    chk("status_rst", 16'h0000, {9'h000, irq_status});
    chk("count_rst", 16'h0000, {8'h00, count});
    irq_enable = 7'h7f;
    pin_cfg.latch_en = 1'b1;
    for (int i = 0; i < 6; i++) begin
      pin_cfg.active_low = (i % 3) != 0;
      pin_cfg.open_drain = (i % 3) == 2;
      pin_cfg.clear_on_read = i[0];
      pulse_evt(i);
      chk("status_set", 16'(1 << i), {9'h000, irq_status});
      chk("pin_on", 16'h0001, {15'h0000, irq_seen});
      @(negedge core_clk);
      if (i[0]) status_read = 1'b1;
      else status_clear = 1'b1;
      @(negedge core_clk);
      status_read = 1'b0;
      status_clear = 1'b0;
      chk("status_clr", 16'h0000, {9'h000, irq_status});
      chk("pin_off", 16'h0000, {15'h0000, irq_seen});
    end
    irq_enable = 7'h7c;
    pulse_evt(0);
    chk("status_masked", 16'h0000, {9'h000, irq_status});
    pin_cfg.latch_en = 1'b0;
    pulse_evt(1);
    chk("status_masked_pulse", 16'h0000, {9'h000, irq_status});
    irq_enable = 7'h7f;
    pulse_evt(1);
    chk("pulse_set", 16'h0002, {9'h000, irq_status});
    @(negedge core_clk);
    chk("pulse_gone", 16'h0000, {9'h000, irq_status});
    pin_cfg.latch_en = 1'b1;
    $display("test events done");
    sample(x_last);
    sample(x_last + 16'sd100);
    chk("count_at_thr", 16'h0000, {8'h00, count});
    sample(x_last + 16'sd101);
    chk("count_above", 16'h0001, {8'h00, count});
    cnt_thr = 8'h03;
    build(1);
    chk("motion_early", 16'h0000, {15'h0000, irq_status[6]});
    build(1);
    chk("motion_flag", 16'h0001, {15'h0000, irq_status[6]});
    chk("axis_x", 16'h0002, {14'h0000, axis[5:4]});
    chk("axis_yz", 16'h0000, {12'h000, axis[3:0]});
    cnt_thr = 8'h00;
    $display("test motion done");
    dec_case(5, 2'h0, 8'h00);
    dec_case(5, 2'h1, 8'h04);
    dec_case(5, 2'h2, 8'h03);
    dec_case(5, 2'h3, 8'h01);
    dec_case(1, 2'h3, 8'h00);
    $display("test decrement done");
    // shift 1: a held step halves on each sample instead of vanishing at once
    hpf_shift = 4'h1;
    dec_ctl = 2'h1;
    sample(x_last + 16'sd400);
    sample(x_last);
    chk("hpf_settling", 16'h0002, {8'h00, count});
    sample(x_last);
    chk("hpf_decayed", 16'h0001, {8'h00, count});
    $display("test filter done");
    complete_run();
  end
endmodule // testbench
`default_nettype wire

/* File: verilog/motion_interrupt_controller.sv */
// interrupt collection, motion detector and interrupt pin driver
`timescale 1ns/1ps
`default_nettype none

// How it works
// - pin polarity, drive, latch and clear configurable
// - clock-lock event is an interrupt source
// - data-ready event is an interrupt source
// - auxiliary bus nack is an interrupt source
// - arbitration loss and nack each reportable
// - combined condition drives the one pin
// - every source has its own enable
// - sticky flag per source names the cause
// - status vector readable by the host
// - high-pass filter every accel sample
// - qualify when any axis magnitude exceeds threshold
// - count up qualifying, down otherwise
// - trigger motion when count reaches threshold
// - record axis and polarity at trigger
// - acceleration threshold is one mg per step
// - count threshold is one ms per step
// - non-qualifying clears or subtracts 1, 2, 4
module motion_interrupt_controller #(
  parameter int ACCEL_W = motion_irq_pkg::ACCEL_W,
  parameter int THR_W   = motion_irq_pkg::THR_W,
  parameter int CNT_W   = motion_irq_pkg::CNT_W
) (
  // clock and reset
  input  wire logic                                 core_clk,
  input  wire logic                                 reset_n,
  // event pulses from the other device blocks
  input  wire logic                                 clk_lock_evt,
  input  wire logic                                 data_ready_evt,
  input  wire logic                                 fifo_overflow_evt,
  input  wire logic                                 aux_nack_evt,
  input  wire logic                                 aux_arb_lost_evt,
  input  wire logic                                 slv4_done_evt,
  // accelerometer samples
  input  wire motion_irq_pkg::accel_sample_t        accel_in,
  // configuration
  input  wire logic [motion_irq_pkg::NUM_FLAGS-1:0] irq_enable,
  input  wire motion_irq_pkg::pin_config_t          pin_cfg,
  input  wire logic [3:0]                           accel_highpass_filter,
  input  wire logic [THR_W-1:0]                     motion_accel_threshold,
  input  wire logic [CNT_W-1:0]                     motion_count_threshold,
  input  wire logic [1:0]                           motion_decrement_control,
  // host status access
  input  wire logic                                 status_read,
  input  wire logic                                 status_clear,
  output logic [motion_irq_pkg::NUM_FLAGS-1:0]      irq_status,
  output motion_irq_pkg::axis_status_t              motion_axis_status,
  output logic [CNT_W-1:0]                          motion_count,
  // interrupt pin
  output logic                                      irq_pin_out,
  output logic                                      irq_pin_oe
);

  // two guard bits: hp + x - x_prev - (hp >>> s) spans four full-scale terms
  localparam int SH_W = ACCEL_W + 2;
  localparam logic signed [SH_W-1:0] HP_MAX = SH_W'((2 ** (ACCEL_W - 1)) - 1);
  localparam logic signed [SH_W-1:0] HP_MIN = -HP_MAX;

  // ---------------- high-pass filter ----------------
  logic signed [ACCEL_W-1:0] hp_reg      [3];
  logic signed [ACCEL_W-1:0] prev_reg    [3];
  logic signed [ACCEL_W-1:0] hp_next     [3];
  logic signed [ACCEL_W-1:0] raw         [3];
  logic        [5:0]         axis_hit;
  logic                      sample_ok;

  assign raw[0] = accel_in.x;
  assign raw[1] = accel_in.y;
  assign raw[2] = accel_in.z;

  // the filter is first order; a constant input decays to zero (a positive residue below 2**shift stays), removing gravity
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_axis
      logic signed [SH_W-1:0] sum;
      logic signed [SH_W-1:0] mag;
      assign sum = SH_W'(hp_reg[g]) + SH_W'(raw[g]) - SH_W'(prev_reg[g])
                   - SH_W'(hp_reg[g] >>> accel_highpass_filter);
      // clamp to the sample width so a large step cannot wrap the sign
      assign hp_next[g] = (sum > HP_MAX) ? HP_MAX[ACCEL_W-1:0] :
                          (sum < HP_MIN) ? HP_MIN[ACCEL_W-1:0] : sum[ACCEL_W-1:0];
      assign mag = hp_next[g][ACCEL_W-1] ? -SH_W'(hp_next[g]) : SH_W'(hp_next[g]);
      // threshold counts directly in mg, the sample unit
      assign axis_hit[5-2*g]   = !hp_next[g][ACCEL_W-1] &&
                                 (mag > SH_W'(motion_accel_threshold));
      assign axis_hit[4-2*g]   = hp_next[g][ACCEL_W-1] &&
                                 (mag > SH_W'(motion_accel_threshold));

      always_ff @(posedge core_clk) begin
        if (!reset_n) begin
          hp_reg[g]   <= '0;
          prev_reg[g] <= '0;
        end else if (accel_in.valid) begin
          hp_reg[g]   <= hp_next[g];
          prev_reg[g] <= raw[g];
        end
      end
    end
  endgenerate

  assign sample_ok = |axis_hit;

  // ---------------- qualifying counter ----------------
  logic [CNT_W-1:0] count_reg;
  logic [CNT_W-1:0] count_next;
  logic [CNT_W-1:0] dec_amt;
  logic             motion_trig;
  motion_irq_pkg::decrement_mode_t dec_mode;

  assign dec_mode = motion_irq_pkg::decrement_mode_t'(motion_decrement_control);

  // clear is a full-scale step, which the floor in count_next turns into zero
  always_comb begin
    case (dec_mode)
      motion_irq_pkg::DEC_CLEAR: dec_amt = '1;
      motion_irq_pkg::DEC_ONE:   dec_amt = CNT_W'(1);
      motion_irq_pkg::DEC_TWO:   dec_amt = CNT_W'(2);
      motion_irq_pkg::DEC_FOUR:  dec_amt = CNT_W'(4);
      default:                   dec_amt = '1;
    endcase
  end

  // one sample per ms, so the count threshold reads in ms
  assign count_next = sample_ok ?
                        ((count_reg == '1) ? count_reg : count_reg + CNT_W'(1)) :
                      (count_reg > dec_amt) ? count_reg - dec_amt : '0;
  // only a qualifying sample carries the count onto the threshold, so a trigger
  // always records at least one axis; a count above it retriggers on each hit
  assign motion_trig = accel_in.valid && sample_ok
                       && (count_next >= motion_count_threshold)
                       && (motion_count_threshold != '0);

  logic [5:0] axis_reg;

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      count_reg <= '0;
      axis_reg  <= '0;
    end else if (accel_in.valid) begin
      count_reg <= count_next;
      if (motion_trig) begin
        axis_reg <= axis_hit;
      end
    end
  end

  // ---------------- source flags ----------------
  logic [motion_irq_pkg::NUM_FLAGS-1:0] evt;
  logic [motion_irq_pkg::NUM_FLAGS-1:0] status_reg;
  logic [motion_irq_pkg::NUM_FLAGS-1:0] status_next;
  logic                                 clear_now;
  logic                                 pin_reg;
  logic                                 pin_next;

  assign evt[motion_irq_pkg::SRC_CLK_LOCK]  = clk_lock_evt;
  assign evt[motion_irq_pkg::SRC_DATA_RDY]  = data_ready_evt;
  assign evt[motion_irq_pkg::SRC_FIFO_OVF]  = fifo_overflow_evt;
  assign evt[motion_irq_pkg::SRC_AUX_NACK]  = aux_nack_evt;
  assign evt[motion_irq_pkg::SRC_AUX_ARB]   = aux_arb_lost_evt;
  assign evt[motion_irq_pkg::SRC_SLV4_DONE] = slv4_done_evt;
  assign evt[motion_irq_pkg::SRC_MOTION]    = motion_trig;

  // the configured method picks the clearing strobe; the other strobe is ignored
  assign clear_now = pin_cfg.clear_on_read ? status_read : status_clear;
  // a new event in the clearing cycle survives: set wins
  assign status_next = ((clear_now || !pin_cfg.latch_en) ? '0 : status_reg)
                       | (evt & irq_enable);
  // latched: pin follows sticky flags; unlatched: flags last one cycle as a pulse
  assign pin_next = |status_next;

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      status_reg <= '0;
      pin_reg    <= 1'b0;
    end else begin
      status_reg <= status_next;
      pin_reg    <= pin_next;
    end
  end

  assign irq_status         = status_reg;
  assign motion_axis_status = axis_reg;
  assign motion_count       = count_reg;

  // open drain drives only the asserted level
  assign irq_pin_out = pin_reg ^ pin_cfg.active_low;
  assign irq_pin_oe  = pin_cfg.open_drain ? pin_reg : 1'b1;

  // ---------------- checks ----------------
  // every property runs on core_clk and sleeps through the synchronous reset;
  // most look at the registered outputs the host sees, one edge after the cause,
  // so a broken next-value term shows up where software would notice it

  // source flags
  a_flag_set_wins: assert property (@(posedge core_clk) disable iff (!reset_n)
    (clk_lock_evt && irq_enable[0])
    |=> irq_status[0])
    else $error("enabled clock lock event not flagged");

  a_disabled_src_quiet: assert property (@(posedge core_clk) disable iff (!reset_n)
    (!irq_enable[1] && (clear_now || !pin_cfg.latch_en))
    |=> !irq_status[1])
    else $error("disabled source set its flag");

  a_latched_holds: assert property (@(posedge core_clk) disable iff (!reset_n)
    (pin_cfg.latch_en && !clear_now && irq_status[3])
    |=> irq_status[3])
    else $error("latched flag dropped without clear");

  a_clear_empties: assert property (@(posedge core_clk) disable iff (!reset_n)
    (pin_cfg.latch_en && clear_now && !(|(evt & irq_enable)))
    |=> (irq_status == '0))
    else $error("status not emptied by clear");

  a_unlatched_pulse: assert property (@(posedge core_clk) disable iff (!reset_n)
    (!pin_cfg.latch_en && !(|(evt & irq_enable)))
    |=> (irq_status == '0))
    else $error("unlatched flag outlived its event");

  // pin driver
  a_pin_tracks_status: assert property (@(posedge core_clk) disable iff (!reset_n)
    (|irq_status) == pin_reg)
    else $error("pin disagrees with status");

  a_pin_level: assert property (@(posedge core_clk) disable iff (!reset_n)
    (|irq_status)
    |-> (irq_pin_out == !pin_cfg.active_low))
    else $error("asserted pin has the wrong polarity");

  a_push_pull_on: assert property (@(posedge core_clk) disable iff (!reset_n)
    !pin_cfg.open_drain
    |-> irq_pin_oe)
    else $error("push-pull pin not driven");

  a_open_drain_off: assert property (@(posedge core_clk) disable iff (!reset_n)
    (pin_cfg.open_drain && (irq_status == '0))
    |-> !irq_pin_oe)
    else $error("open-drain pin driven while idle");

  // qualifying counter
  a_count_up: assert property (@(posedge core_clk) disable iff (!reset_n)
    (accel_in.valid && sample_ok && (count_reg != '1))
    |=> (count_reg == $past(count_reg) + 1))
    else $error("counter did not count up");

  a_count_idle: assert property (@(posedge core_clk) disable iff (!reset_n)
    !accel_in.valid
    |=> $stable(count_reg))
    else $error("counter moved without a sample");

  a_count_clear: assert property (@(posedge core_clk) disable iff (!reset_n)
    (accel_in.valid && !sample_ok && (dec_mode == motion_irq_pkg::DEC_CLEAR))
    |=> (count_reg == '0))
    else $error("counter not cleared");

  a_count_minus_one: assert property (@(posedge core_clk) disable iff (!reset_n)
    (accel_in.valid && !sample_ok && (dec_mode == motion_irq_pkg::DEC_ONE)
     && (count_reg >= 1)) |=> (count_reg == $past(count_reg) - 1))
    else $error("counter did not drop by one");

  a_count_minus_two: assert property (@(posedge core_clk) disable iff (!reset_n)
    (accel_in.valid && !sample_ok && (dec_mode == motion_irq_pkg::DEC_TWO)
     && (count_reg >= 2)) |=> (count_reg == $past(count_reg) - 2))
    else $error("counter did not drop by two");

  a_count_minus_four: assert property (@(posedge core_clk) disable iff (!reset_n)
    (accel_in.valid && !sample_ok && (dec_mode == motion_irq_pkg::DEC_FOUR)
     && (count_reg >= 4)) |=> (count_reg == $past(count_reg) - 4))
    else $error("counter did not drop by four");

  a_count_floor: assert property (@(posedge core_clk) disable iff (!reset_n)
    (accel_in.valid && !sample_ok && (count_reg < 4))
    |=> (count_reg <= $past(count_reg)))
    else $error("counter wrapped below zero");

  // motion trigger
  a_motion_flag: assert property (@(posedge core_clk) disable iff (!reset_n)
    (motion_trig && irq_enable[6])
    |=> (irq_status[6] && (motion_axis_status != '0)))
    else $error("motion trigger not recorded");

  a_axis_hold: assert property (@(posedge core_clk) disable iff (!reset_n)
    !motion_trig
    |=> $stable(motion_axis_status))
    else $error("axis status changed without a trigger");

  // main scenarios
  c_motion_trigger: cover property (@(posedge core_clk) disable iff (!reset_n) motion_trig);
  c_set_during_clear: cover property (@(posedge core_clk) disable iff (!reset_n)
    clear_now && |(evt & irq_enable));
  c_count_decay: cover property (@(posedge core_clk) disable iff (!reset_n)
    accel_in.valid && !sample_ok && count_reg > 4);
  c_unlatched_event: cover property (@(posedge core_clk) disable iff (!reset_n)
    !pin_cfg.latch_en && |(evt & irq_enable));
  c_open_drain_drive: cover property (@(posedge core_clk) disable iff (!reset_n)
    pin_cfg.open_drain && irq_pin_oe);

endmodule // motion_interrupt_controller

`default_nettype wire

/* File: verilog/motion_irq_pkg.sv */
// shared constants and carrier types for the motion interrupt controller
package motion_irq_pkg;

  localparam int ACCEL_W        = 16;
  localparam int THR_W          = 8;
  localparam int CNT_W          = 8;
  // one threshold step is one milli-g; one count step is one sample at 1 khz, i.e. 1 ms
  localparam int ACCEL_THR_STEP_MG = 1;
  localparam int COUNT_STEP_MS     = 1;
  // high-pass filter: y += x - x_prev - (y >> shift); shift sets the corner
  localparam logic [3:0] HPF_SHIFT_RESET = 4'h4;
  localparam logic [1:0] DEC_RESET       = 2'h0;
  localparam int NUM_SRC        = 6;
  // source positions in the enable and status vectors
  localparam int SRC_CLK_LOCK   = 0;
  localparam int SRC_DATA_RDY   = 1;
  localparam int SRC_FIFO_OVF   = 2;
  localparam int SRC_AUX_NACK   = 3;
  localparam int SRC_AUX_ARB    = 4;
  localparam int SRC_SLV4_DONE  = 5;
  localparam int SRC_MOTION     = 6;
  localparam int NUM_FLAGS      = 7;

  typedef enum logic [1:0] {
    DEC_CLEAR = 2'b00,
    DEC_ONE   = 2'b01,
    DEC_TWO   = 2'b10,
    DEC_FOUR  = 2'b11
  } decrement_mode_t;

  typedef struct packed {
    logic                       valid;
    logic signed [ACCEL_W-1:0]  x;
    logic signed [ACCEL_W-1:0]  y;
    logic signed [ACCEL_W-1:0]  z;
  } accel_sample_t;

  typedef struct packed {
    logic       active_low;   // pin polarity
    logic       open_drain;   // drive asserted level only
    logic       latch_en;     // hold pin until cleared
    logic       clear_on_read;// status read clears, else status_clear pulse
  } pin_config_t;

  // axis and polarity of the triggering sample: {x_pos,x_neg,y_pos,y_neg,z_pos,z_neg}
  typedef logic [5:0] axis_status_t;

endpackage : motion_irq_pkg
